/* File: hdl/hed_event_diag.sv */
// Event flags, masks, alert line and playback hold for the haptic driver
//
// Function
// - Any fault forces idle until cleared
// - Warnings and notifications never stop drive
// - Events pull open-drain alert low
// - All faults in one summary byte
// - Warning and input-fault details reported separately
// - Write one clears, zero keeps
// - Overcurrent, overtemperature, undervoltage set faults
// - Impedance, back-EMF or frequency set actuator fault
// - Input-data faults set sequence summary fault
// - Stored sequence end sets done
// - Repeat request restart sets repeat flag
// - Warning summary while any warning
// - Sense converter saturation sets notification
// - Drive and boost limit warnings
// - Data format mismatch raises warning
// - Missing pattern ID raises flag
// - Corrupt pattern store raises flag
// - Frequency outside 50-300 Hz faults unless bypassed; the window is only judged while i_playing is high
// - Instant period updated each half-period
// - Average period over last four halves
// - Hostless mode clears faults entering inactive
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "hed_consts.svh"
module hed_event_diag
   import hed_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_overcurrent,
   input wire logic i_overtemp,
   input wire logic i_undervolt,
   input wire logic i_act_impedance,
   input wire logic i_act_bemf,
   input wire logic i_drive_limited,
   input wire logic i_boost_limited,
   input wire logic i_format_mismatch,
   input wire logic i_adc_sat,
   input wire logic i_bad_id,
   input wire logic i_store_corrupt,
   input wire logic i_pwm_timeout,
   input wire logic i_play_done,
   input wire logic i_play_repeat,
   input wire logic i_playing,
   input wire logic i_zero_cross,
   output logic o_force_idle,
   output logic o_event_alert_n_out,
   output logic o_event_alert_n_oe
);
   // Register port and event sources gathered into carrier structs
   hed_bus_type bus;
   hed_src_type src_raw;
   hed_src_type s1_reg;
   hed_src_type s2_reg;
   hed_src_type s3_reg;
   hed_src_type src_reg;
   hed_src_type src_next;
   hed_src_type src_dly_reg;
   hed_src_type src_rise;
   // Playback hold state
   hed_play_type play_reg;
   hed_play_type play_next;
   // Flag groups and their next values
   logic [7:0] fault_reg;
   logic [7:0] fault_next;
   logic [7:0] notify_reg;
   logic [7:0] notify_next;
   logic [7:0] warn_reg;
   logic [7:0] warn_next;
   logic [7:0] infault_reg;
   logic [7:0] infault_next;
   // Software registers and read path
   logic [7:0] mask_a_reg;
   logic [7:0] mask_b_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] rdata_next;
   logic [7:0] fault_set;
   logic [7:0] notify_set;
   logic [7:0] warn_set;
   logic [7:0] infault_set;
   // Period readout and internal decisions
   logic [15:0] inst_ticks;
   logic [15:0] avg_ticks;
   logic period_sample;
   logic freq_bad;
   logic hostless_clear;
   logic any_fault;
   logic alert;
   logic fault_alert;
   logic notify_alert;
   logic playing_dly_reg;

   assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
   assign src_raw = '{overcurrent: i_overcurrent, overtemp: i_overtemp,
      undervolt: i_undervolt, act_impedance: i_act_impedance, act_bemf: i_act_bemf,
      drive_limited: i_drive_limited, boost_limited: i_boost_limited,
      format_mismatch: i_format_mismatch, adc_sat: i_adc_sat, bad_id: i_bad_id,
      store_corrupt: i_store_corrupt, pwm_timeout: i_pwm_timeout,
      play_done: i_play_done, play_repeat: i_play_repeat};

   // Sources come from analog monitors; three stages, a change counts once 2 and 3 agree
   // Only the second stage reads the first, so no logic sees a metastable value
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= src_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A filtered bit only moves once the last two stages agree, so a single
   // glitching sample never reaches the flags
   genvar b;
   generate
      for (b = 0; b < $bits(hed_src_type); b++) begin : g_filt
         assign src_next[b] = (s2_reg[b] == s3_reg[b]) ? s3_reg[b] : src_reg[b];
      end
   endgenerate

   // Filtered level and its previous value for edge detection; both reset to the
   // idle low level of the monitors so no false edge follows reset
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         src_reg <= '0;
         src_dly_reg <= '0;
      end else begin
         src_reg <= src_next;
         src_dly_reg <= src_reg;
      end
   end

   // Flags latch on the rising edge so a persisting condition re-flags only if it recurs
   assign src_rise = src_reg & ~src_dly_reg;

   // Resonant period measurement; results and their sample strobe arrive together,
   // so the window check below always judges the half-period that just closed
   hed_period_meter u_meter (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_zero_cross(i_zero_cross),
      .o_inst_ticks(inst_ticks),
      .o_avg_ticks(avg_ticks),
      .o_sample(period_sample)
   );

   // The window is only judged while the actuator is driven: between playbacks
   // the counter runs to saturation and would read as a far too long period
   // frequency window check
   assign freq_bad = period_sample && !ctrl_reg[`HED_C_BYPASS] && i_playing &&
      (inst_ticks > 16'(`HED_HALF_MAX_TICKS) || inst_ticks < 16'(`HED_HALF_MIN_TICKS));

   // Input-data fault detail set terms
   // missing pattern id
   assign infault_set[`HED_I_ID] = src_rise.bad_id;
   assign infault_set[`HED_I_MEM] = src_rise.store_corrupt;
   // PWM timeout: the host clears it through the sequence summary bit
   assign infault_set[`HED_I_PWM] = src_rise.pwm_timeout;
   assign infault_set[7:3] = 5'h00;

   // Warning detail set terms
   // drive and boost limits
   assign warn_set[`HED_W_DRIVE] = src_rise.drive_limited;
   assign warn_set[`HED_W_BOOST] = src_rise.boost_limited;
   assign warn_set[`HED_W_FORMAT] = src_rise.format_mismatch;
   assign warn_set[7:3] = 5'h00;

   // Fault summary set terms
   // supply and thermal faults
   assign fault_set[`HED_F_OC] = src_rise.overcurrent;
   assign fault_set[`HED_F_OT] = src_rise.overtemp;
   assign fault_set[`HED_F_UV] = src_rise.undervolt;
   assign fault_set[`HED_F_ACT] = src_rise.act_impedance | src_rise.act_bemf | freq_bad;
   assign fault_set[`HED_F_SEQ] = |infault_set;
   assign fault_set[7:5] = 3'h0;

   // Notification set terms
   // sequence done
   assign notify_set[`HED_N_DONE] = src_rise.play_done;
   assign notify_set[`HED_N_REPEAT] = src_rise.play_repeat;
   // The summary is set again every cycle a warning stays in the detail group,
   // so clearing it only sticks once the details themselves are cleared
   // warning summary follows detail group
   assign notify_set[`HED_N_WARN] = |warn_reg;
   assign notify_set[`HED_N_SAT] = src_rise.adc_sat;
   assign notify_set[7:4] = 4'h0;

   // Inactive lasts exactly one cycle, so the automatic clear is a single pulse;
   // a fault edge in that same cycle survives because set wins
   // hostless clear when playback ends into inactive
   assign hostless_clear = ctrl_reg[`HED_C_HOSTLESS] && (play_reg == HED_INACTIVE);

   // Clear terms are built from the write strobe and the hostless clear; a read never disturbs a
   // flag, so the host may poll freely without losing an event
   // write one clears; set wins over clear
   wire wr_fault = bus.wr && bus.addr == `HED_ADDR_FAULT;
   wire wr_notify = bus.wr && bus.addr == `HED_ADDR_NOTIFY;
   wire wr_warn = bus.wr && bus.addr == `HED_ADDR_WARN;
   wire wr_infault = bus.wr && bus.addr == `HED_ADDR_INFAULT;
   wire [7:0] fault_clr = (wr_fault ? bus.wdata : 8'h00) | (hostless_clear ? 8'hff : 8'h00);
   // sequence summary clear also retires the input-fault detail
   wire seq_clr = fault_clr[`HED_F_SEQ];
   assign fault_next = fault_set | (fault_reg & ~fault_clr);
   assign notify_next = notify_set | (notify_reg & ~(wr_notify ? bus.wdata : 8'h00));
   assign warn_next = warn_set | (warn_reg & ~(wr_warn ? bus.wdata : 8'h00));
   assign infault_next = infault_set |
      (infault_reg & ~((wr_infault ? bus.wdata : 8'h00) | (seq_clr ? 8'hff : 8'h00)));

   // One byte per group keeps each group readable in a single access
   // separate flag groups
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         fault_reg <= 8'h00;
         notify_reg <= 8'h00;
         warn_reg <= 8'h00;
         infault_reg <= 8'h00;
      end else begin
         fault_reg <= fault_next;
         notify_reg <= notify_next;
         warn_reg <= warn_next;
         infault_reg <= infault_next;
      end
   end

   // Mask and control registers; unused control bits are dropped so they
   // read back as zero and cannot enable a mode that does not exist
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         mask_a_reg <= `HED_MASK_RST;
         mask_b_reg <= `HED_MASK_RST;
         ctrl_reg <= `HED_CTRL_RST;
      end else if (bus.wr) begin
         if (bus.addr == `HED_ADDR_MASK_A)
            mask_a_reg <= bus.wdata;
         if (bus.addr == `HED_ADDR_MASK_B)
            mask_b_reg <= bus.wdata;
         if (bus.addr == `HED_ADDR_CTRL)
            ctrl_reg <= bus.wdata & 8'h03;
      end
   end

   // Playback hold state: faults only; warnings and notifications never enter here.
   // Run passes through inactive on every stop, faulted or not, so the hostless
   // clear sees both ways of leaving playback
   assign any_fault = |fault_reg;
   always_comb begin
      play_next = play_reg;
      unique case (play_reg)
         HED_RUN: begin
            // leave run for inactive on fault; other groups ignored
            if (any_fault)
               play_next = HED_INACTIVE;
            else if (playing_dly_reg && !i_playing)
               play_next = HED_INACTIVE;
         end
         HED_INACTIVE: begin
            // One cycle where hostless mode may clear
            play_next = any_fault ? HED_HOLD : HED_RUN;
         end
         HED_HOLD: begin
            // stay idle until all faults cleared
            if (!any_fault)
               play_next = HED_RUN;
         end
         default: play_next = HED_HOLD;
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         play_reg <= HED_RUN;
         playing_dly_reg <= 1'b0;
      end else begin
         play_reg <= play_next;
         playing_dly_reg <= i_playing;
      end
   end

   // The live flag term stops drive in the very cycle a fault is flagged, two
   // cycles before the state machine reaches HED_HOLD
   // force idle from state or any live fault flag
   assign o_force_idle = any_fault || play_reg == HED_HOLD;

   // A mask bit only hides the line; the flag itself stays readable so the
   // host can still poll it
   // mask per event group
   assign fault_alert = |(fault_reg & ~mask_a_reg);
   assign notify_alert = |(notify_reg & ~mask_b_reg);
   // line held while any unmasked flag stays set
   assign alert = fault_alert || notify_alert;

   // open-drain alert: drive low when enabled
   assign o_event_alert_n_out = 1'b0;
   assign o_event_alert_n_oe = alert;

   // Read mux; unmapped addresses read zero. The period fields are 15 bits wide,
   // so the top counter bit is never shown; a saturated count reads as the
   // largest value in both halves
   always_comb begin
      unique case (bus.addr)
         `HED_ADDR_FAULT: rdata_next = fault_reg;
         `HED_ADDR_NOTIFY: rdata_next = notify_reg;
         `HED_ADDR_WARN: rdata_next = warn_reg;
         `HED_ADDR_INFAULT: rdata_next = infault_reg;
         `HED_ADDR_MASK_A: rdata_next = mask_a_reg;
         `HED_ADDR_MASK_B: rdata_next = mask_b_reg;
         `HED_ADDR_CTRL: rdata_next = ctrl_reg;
         // instant period high/low split at 128
         `HED_ADDR_INST_H: rdata_next = inst_ticks[14:7];
         `HED_ADDR_INST_L: rdata_next = {1'b0, inst_ticks[6:0]};
         `HED_ADDR_AVG_H: rdata_next = avg_ticks[14:7];
         `HED_ADDR_AVG_L: rdata_next = {1'b0, avg_ticks[6:0]};
         `HED_ADDR_STATUS: rdata_next = {5'h00, alert, 2'(play_reg)};
         default: rdata_next = 8'h00;
      endcase
   end

   // Read data stands in the cycle after the strobe only, and is zero otherwise
   // so a shared read bus stays quiet
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst)
         o_rdata <= 8'h00;
      else
         o_rdata <= bus.rd ? rdata_next : 8'h00;
   end
endmodule

/* File: hdl/hed_consts.svh */
// Register offsets, field positions, reset values and timing counts for the event block
`ifndef HED_CONSTS_SVH
`define HED_CONSTS_SVH
`define HED_ADDR_FAULT 8'h00
`define HED_ADDR_NOTIFY 8'h01
`define HED_ADDR_WARN 8'h02
`define HED_ADDR_INFAULT 8'h03
`define HED_ADDR_MASK_A 8'h04
`define HED_ADDR_MASK_B 8'h05
`define HED_ADDR_CTRL 8'h06
`define HED_ADDR_INST_H 8'h07
`define HED_ADDR_INST_L 8'h08
`define HED_ADDR_AVG_H 8'h09
`define HED_ADDR_AVG_L 8'h0a
`define HED_ADDR_STATUS 8'h0b
// Fault byte fields
`define HED_F_OC 0
`define HED_F_ACT 1
`define HED_F_SEQ 2
`define HED_F_OT 3
`define HED_F_UV 4
// Notification byte fields
`define HED_N_DONE 0
`define HED_N_REPEAT 1
`define HED_N_WARN 2
`define HED_N_SAT 3
// Warning detail fields
`define HED_W_DRIVE 0
`define HED_W_BOOST 1
`define HED_W_FORMAT 2
// Input-fault detail fields
`define HED_I_ID 0
`define HED_I_MEM 1
`define HED_I_PWM 2
// Control fields
`define HED_C_BYPASS 0
`define HED_C_HOSTLESS 1
// Reset values
`define HED_MASK_RST 8'h00
`define HED_CTRL_RST 8'h00
// Period tick is 1333.32 ns; the window is 50 Hz to 300 Hz
`define HED_TICK_PS 1333320
`define HED_PER_MAX_PS 64'd20000000000
`define HED_PER_MIN_PS 64'd3333333333
// Half-period limits in ticks: longest rounds down, shortest rounds up
`define HED_HALF_MAX_TICKS ((`HED_PER_MAX_PS / 2) / `HED_TICK_PS)
`define HED_HALF_MIN_TICKS ((`HED_PER_MIN_PS / 2 + `HED_TICK_PS - 1) / `HED_TICK_PS)
// Clock is 125 MHz; tick divider length derived from the tick period
`define HED_CLK_PS 8000
`define HED_TICK_CYCLES ((`HED_TICK_PS + `HED_CLK_PS / 2) / `HED_CLK_PS)
`endif

/* File: hdl/hed_pkg.sv */
// Types shared by the event and diagnostics block
package hed_pkg;
   typedef struct packed {
      logic overcurrent;
      logic overtemp;
      logic undervolt;
      logic act_impedance;
      logic act_bemf;
      logic drive_limited;
      logic boost_limited;
      logic format_mismatch;
      logic adc_sat;
      logic bad_id;
      logic store_corrupt;
      logic pwm_timeout;
      logic play_done;
      logic play_repeat;
   } hed_src_type;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } hed_bus_type;
   typedef enum logic [1:0] {
      HED_RUN = 2'b00,
      HED_HOLD = 2'b01,
      HED_INACTIVE = 2'b10
   } hed_play_type;
endpackage

/* File: hdl/hed_period_meter.sv */
// Resonant half-period meter with instantaneous and four-sample average
`timescale 1ns/1ns
`include "hed_consts.svh"
module hed_period_meter
   import hed_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_zero_cross,
   output logic [15:0] o_inst_ticks,
   output logic [15:0] o_avg_ticks,
   output logic o_sample
);
   logic [7:0] div_reg;
   logic [15:0] cnt_reg;
   logic [15:0] hist_reg [0:2];
   logic [15:0] hist_next [0:2];
   logic [17:0] sum;
   wire tick = (div_reg == 8'(`HED_TICK_CYCLES - 1));

   // Average of the four most recent half-periods, the one closing now included,
   // so the average and the instant value are published in the same cycle
   assign sum = {2'b00, cnt_reg} + {2'b00, hist_reg[0]} + {2'b00, hist_reg[1]} +
      {2'b00, hist_reg[2]};

   // Tick divider and half-period counter, saturating to avoid wrap on a stalled actuator
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         div_reg <= 8'h00;
         cnt_reg <= 16'h0000;
      end else begin
         div_reg <= tick ? 8'h00 : div_reg + 8'h01;
         if (i_zero_cross)
            cnt_reg <= 16'h0000;
         else if (tick && cnt_reg != 16'hffff)
            cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // History shift on each zero crossing
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_hist
         assign hist_next[g] = (g == 0) ? cnt_reg : hist_reg[(g == 0) ? 0 : g - 1];
      end
   endgenerate

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst)
         hist_reg <= '{default: 16'h0000};
      else if (i_zero_cross)
         hist_reg <= hist_next;
   end

   // Result registers
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_inst_ticks <= 16'h0000;
         o_avg_ticks <= 16'h0000;
         o_sample <= 1'b0;
      end else begin
         // Results and strobe land together, so the strobe marks fresh values
         o_sample <= i_zero_cross;
         if (i_zero_cross) begin
            o_inst_ticks <= cnt_reg;
            o_avg_ticks <= sum[17:2];
         end
      end
   end
endmodule

/* File: tb/hed_host_side.sv */
// Host side of the alert line: pull-up and the level the host sees
`timescale 1ns/1ns
module hed_host_side (
   input wire logic i_alert_oe,
   input wire logic i_alert_out,
   output logic o_alert_line
);
   // Released open-drain line floats up to the pull-up level, never holds the last value
   assign o_alert_line = i_alert_oe ? i_alert_out : 1'b1;
endmodule

/* File: tb/hed_event_diag_sva.sv */
// Checker for alert drive, idle hold and read port of the event block
`timescale 1ns/1ns
`include "hed_consts.svh"
module hed_event_diag_chk (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_overcurrent,
   input wire logic i_drive_limited,
   input wire logic i_play_done,
   input wire logic o_force_idle,
   input wire logic o_event_alert_n_out,
   input wire logic o_event_alert_n_oe
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // Shadow of the notification mask, so masked and unmasked events can be told apart
   logic [7:0] mask_b_reg;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) mask_b_reg <= 8'h00;
      else if (i_wr && i_addr == `HED_ADDR_MASK_B) mask_b_reg <= i_wdata;
   end
   // Shadow of the hostless bit: that mode clears faults with no write at all
   logic hostless_reg;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) hostless_reg <= 1'b0;
      else if (i_wr && i_addr == `HED_ADDR_CTRL) hostless_reg <= i_wdata[`HED_C_HOSTLESS];
   end
   chk_alert_drive_low: assert property (o_event_alert_n_out == 1'b0)
      else $error("alert line driven high");
   chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   chk_fault_idle: assert property ($rose(i_overcurrent) |-> ##[1:10] o_force_idle)
      else $error("fault did not force idle");
   chk_warn_no_stop: assert property ($rose(i_drive_limited) && !o_force_idle
      |=> !o_force_idle [*8]) else $error("warning stopped drive");
   chk_done_alert: assert property ($rose(i_play_done) && !mask_b_reg[`HED_N_DONE]
      |-> ##[1:10] o_event_alert_n_oe) else $error("done event did not pull alert");
   chk_mask_quiet: assert property ($rose(i_play_done) && mask_b_reg == 8'hff
      && !o_event_alert_n_oe |=> !o_event_alert_n_oe [*8]) else $error("masked event alerted");
   chk_idle_hold: assert property (o_force_idle && !i_wr && !$past(i_wr)
      && !$past(i_wr, 2) && !hostless_reg |=> o_force_idle)
      else $error("idle released without clear");
   chk_alert_hold: assert property (o_event_alert_n_oe && !i_wr && !$past(i_wr)
      && !hostless_reg |=> o_event_alert_n_oe) else $error("alert released without clear");
endmodule
bind hed_event_diag hed_event_diag_chk u_chk (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr,
   .i_rd, .o_rdata, .i_overcurrent, .i_drive_limited, .i_play_done, .o_force_idle,
   .o_event_alert_n_out, .o_event_alert_n_oe);

/* File: tb/testbench.sv */
// Self-checking bench for event flags, masks, alert line and period readout
`timescale 1ns/1ns
`include "hed_consts.svh"
module testbench
   import hed_pkg::*;
;
   logic i_clk_sys, i_rst, i_playing, i_zero_cross;
   logic rd_q = 1'b0;
   hed_bus_type bus;
   hed_src_type src;
   logic [7:0] o_rdata, want;
   logic o_force_idle, alert_out, alert_oe, alert_line;
   int n_errors = 0;
   int samples_checked = 0;
   logic [7:0] exp_q[$];
   // Event table indexed by source bit: register holding the flag and its bit value
   logic [7:0] ev_addr [14] = '{8'h01, 8'h01, 8'h03, 8'h03, 8'h03, 8'h01, 8'h02, 8'h02,
      8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] ev_bit [14] = '{8'h02, 8'h01, 8'h04, 8'h02, 8'h01, 8'h08, 8'h04, 8'h02,
      8'h01, 8'h02, 8'h02, 8'h10, 8'h08, 8'h01};
   hed_event_diag u_hed_event_diag (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(bus.addr), .i_wdata(bus.wdata),
      .i_wr(bus.wr), .i_rd(bus.rd), .o_rdata(o_rdata),
      .i_overcurrent(src.overcurrent), .i_overtemp(src.overtemp),
      .i_undervolt(src.undervolt), .i_act_impedance(src.act_impedance),
      .i_act_bemf(src.act_bemf), .i_drive_limited(src.drive_limited),
      .i_boost_limited(src.boost_limited), .i_format_mismatch(src.format_mismatch),
      .i_adc_sat(src.adc_sat), .i_bad_id(src.bad_id), .i_store_corrupt(src.store_corrupt),
      .i_pwm_timeout(src.pwm_timeout), .i_play_done(src.play_done),
      .i_play_repeat(src.play_repeat), .i_playing(i_playing), .i_zero_cross(i_zero_cross),
      .o_force_idle(o_force_idle), .o_event_alert_n_out(alert_out),
      .o_event_alert_n_oe(alert_oe));
   hed_host_side u_host (.i_alert_oe(alert_oe), .i_alert_out(alert_out),
      .o_alert_line(alert_line));
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end
   task automatic compare(input logic [7:0] got, input logic [7:0] exp_v);
      samples_checked++;
      if (got !== exp_v) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp_v);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge i_clk_sys);
      bus.wr <= 1'b0;
   endtask
   // Read notes its expectation; the monitor below compares in the answer cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk_sys);
      bus.addr <= a;
      bus.rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge i_clk_sys);
      bus.rd <= 1'b0;
   endtask
   always @(posedge i_clk_sys) begin
      if (rd_q) begin
         want = exp_q.pop_front();
         compare(o_rdata, want);
      end
      rd_q <= bus.rd;
   end
   // One event: raise, check idle and alert, write-zero keeps, write-one clears
   task automatic run_event(input int i, input logic masked);
      logic [7:0] a, b;
      logic fault;
      a = ev_addr[i];
      b = ev_bit[i];
      fault = (a == `HED_ADDR_FAULT) || (a == `HED_ADDR_INFAULT);
      src[i] <= 1'b1;
      repeat (10) @(posedge i_clk_sys);
      compare({7'h00, o_force_idle}, {7'h00, fault});
      compare({7'h00, alert_line}, {7'h00, masked});
      src[i] <= 1'b0;
      rd(a, b);
      if (a == `HED_ADDR_WARN) rd(`HED_ADDR_NOTIFY, 8'h04);
      if (a == `HED_ADDR_INFAULT) rd(`HED_ADDR_FAULT, 8'h04);
      wr(a, 8'($urandom) & ~b);
      rd(a, b);
      wr(a, b);
      if (a == `HED_ADDR_WARN) wr(`HED_ADDR_NOTIFY, 8'h04);
      if (a == `HED_ADDR_INFAULT) wr(`HED_ADDR_FAULT, 8'h04);
      rd(a, 8'h00);
      rd(`HED_ADDR_FAULT, 8'h00);
      rd(`HED_ADDR_NOTIFY, 8'h00);
      repeat (4) @(posedge i_clk_sys);
      compare({7'h00, o_force_idle}, 8'h00);
      compare({7'h00, alert_line}, 8'h01);
   endtask
   // Half-period of exactly 64 ticks whatever the divider phase, well inside the
   // short-period fault zone
   task automatic pulse_zc();
      repeat (64 * `HED_TICK_CYCLES) @(posedge i_clk_sys);
      i_zero_cross <= 1'b1;
      @(posedge i_clk_sys);
      i_zero_cross <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #(8 * 90000);
      n_errors++;
      end_of_test();
   end
   initial begin
      i_rst = 1'b1;
      bus = '0;
      src = '0;
      i_playing = 1'b0;
      i_zero_cross = 1'b0;
      void'($urandom(32'h938395eb));
      repeat (5) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rd(`HED_ADDR_MASK_A, `HED_MASK_RST);
      rd(`HED_ADDR_MASK_B, `HED_MASK_RST);
      rd(`HED_ADDR_CTRL, `HED_CTRL_RST);
      rd(8'h0c, 8'h00);
      wr(`HED_ADDR_CTRL, 8'hff);
      rd(`HED_ADDR_CTRL, 8'h03);
      // Hostless mode would clear faults on its own, so it stays off for the events
      wr(`HED_ADDR_CTRL, 8'h00);
      rd(`HED_ADDR_CTRL, 8'h00);
      $display("Test registers done");
      // Every source unmasked, then with both masks full
      for (int m = 0; m < 2; m++) begin
         wr(`HED_ADDR_MASK_A, m ? 8'hff : 8'h00);
         wr(`HED_ADDR_MASK_B, m ? 8'hff : 8'h00);
         for (int i = 0; i < 14; i++) run_event(i, m[0]);
      end
      wr(`HED_ADDR_MASK_A, 8'h00);
      wr(`HED_ADDR_MASK_B, 8'h00);
      $display("Test events done");
      wr(`HED_ADDR_CTRL, 8'h01);
      i_playing <= 1'b1;
      repeat (5) pulse_zc();
      rd(`HED_ADDR_FAULT, 8'h00);
      rd(`HED_ADDR_INST_H, 8'h00);
      rd(`HED_ADDR_INST_L, 8'h40);
      rd(`HED_ADDR_AVG_H, 8'h00);
      rd(`HED_ADDR_AVG_L, 8'h40);
      wr(`HED_ADDR_CTRL, 8'h00);
      pulse_zc();
      rd(`HED_ADDR_FAULT, 8'h02);
      wr(`HED_ADDR_FAULT, 8'h02);
      i_playing <= 1'b0;
      rd(`HED_ADDR_FAULT, 8'h00);
      $display("Test period done");
      // Hostless mode: a fault forces idle, then clears itself once inactive
      wr(`HED_ADDR_CTRL, 8'h02);
      src.overcurrent <= 1'b1;
      repeat (7) @(posedge i_clk_sys);
      compare({7'h00, o_force_idle}, 8'h01);
      src.overcurrent <= 1'b0;
      repeat (5) @(posedge i_clk_sys);
      compare({7'h00, o_force_idle}, 8'h00);
      compare({7'h00, alert_line}, 8'h01);
      rd(`HED_ADDR_FAULT, 8'h00);
      wr(`HED_ADDR_CTRL, 8'h00);
      $display("Test hostless done");
      repeat (3) @(posedge i_clk_sys);
      end_of_test();
   end
endmodule
